/* src/sag_pkg.sv */
// shared constants and types for the segmented address generator
package sag_pkg;
    localparam int SEG_W = 16;
    localparam int OFS_W = 16;
    localparam int PA_W = 20;
    localparam int SEG_SHIFT = 4;
    localparam int DISP8_W = 8;
    localparam int REG_SEL_W = 3;
    localparam logic [SEG_SHIFT-1:0] SEG_LOW_ZERO = 4'h0;
    localparam logic [SEG_W-1:0] SEG_RESET = 16'h0000;
    localparam logic [OFS_W-1:0] PC_RESET = 16'h0000;
    // far pointer keeps its segment word one word above the offset word
    localparam logic [PA_W-1:0] PTR_HI_STEP = 20'h00002;

    // general register encoding of the 3-bit register field
    localparam logic [REG_SEL_W-1:0] REG_ACC = 3'h0;
    localparam logic [REG_SEL_W-1:0] REG_CNT = 3'h1;
    localparam logic [REG_SEL_W-1:0] REG_DAT = 3'h2;
    localparam logic [REG_SEL_W-1:0] REG_BASE = 3'h3;
    localparam logic [REG_SEL_W-1:0] REG_SP = 3'h4;
    localparam logic [REG_SEL_W-1:0] REG_BP = 3'h5;
    localparam logic [REG_SEL_W-1:0] REG_SRC = 3'h6;
    localparam logic [REG_SEL_W-1:0] REG_DST = 3'h7;

    typedef enum logic [1:0] {
        SAG_SEG_PROG = 2'h0,
        SAG_SEG_STACK = 2'h1,
        SAG_SEG_DATA0 = 2'h2,
        SAG_SEG_DATA1 = 2'h3
    } sag_seg_t;

    typedef enum logic [2:0] {
        SAG_ACC_FETCH = 3'h0,
        SAG_ACC_STACK = 3'h1,
        SAG_ACC_DATA = 3'h2,
        SAG_ACC_BP_DATA = 3'h3,
        SAG_ACC_SRC_BLK = 3'h4,
        SAG_ACC_DST_BLK = 3'h5
    } sag_acc_t;

    typedef enum logic [2:0] {
        SAG_BR_NONE = 3'h0,
        SAG_BR_DIRECT = 3'h1,
        SAG_BR_REL = 3'h2,
        SAG_BR_REG = 3'h3,
        SAG_BR_IND = 3'h4,
        SAG_BR_IDX = 3'h5
    } sag_br_t;

    typedef enum logic [1:0] {
        SAG_ST_IDLE = 2'h0,
        SAG_ST_RD_LO = 2'h1,
        SAG_ST_RD_HI = 2'h2
    } sag_state_t;

    typedef struct packed {
        sag_acc_t kind;
        logic override_en;
        sag_seg_t override_seg;
        logic [OFS_W-1:0] ea;
    } sag_req_t;

    typedef struct packed {
        sag_br_t mode;
        logic far_tgt;
        logic disp_wide;
        logic [OFS_W-1:0] imm_lo;
        logic [OFS_W-1:0] imm_hi;
        logic [REG_SEL_W-1:0] reg_sel;
    } sag_br_req_t;

    typedef struct packed {
        logic [SEG_W-1:0] prog;
        logic [SEG_W-1:0] stack;
        logic [SEG_W-1:0] data0;
        logic [SEG_W-1:0] data1;
    } sag_segs_t;
endpackage

/* src/sag_top.sv */
// segment address generation and branch target unit
// Operation
// [RL1] physical address is segment base times sixteen plus offset
// [RL2] base and offset are both unsigned, never sign extended
// [RL3] drive a twenty-bit physical address covering one megabyte
// [RL4] segment base alone lands only on sixteen-byte boundaries
// [RL5] four sixteen-bit segment bases: program, stack, data zero, data one
// [RL6] instruction fetch uses program base with the prefetch pointer
// [RL7] stack accesses use stack base with the stack pointer
// [RL8] operand based on base pointer defaults to stack base
// [RL9] override prefix replaces the default segment for the operand
// [RL10] plain data operands use data zero base with effective address
// [RL11] block source uses data zero base with source index
// [RL12] block destination uses data one base with destination index
// [RL13] program counter moves to next instruction before each execution
// [RL14] direct branch loads counter, or base and counter for far
// [RL15] relative branch adds sign-extended or wide displacement to counter
// [RL16] relative addition uses address of the following instruction
// [RL17] register branch loads the selected general register into counter
// [RL18] indirect branch reads memory at index or base register
// [RL19] indexed branch adds signed displacement to index, reads memory
// [RL20] carry out of bit nineteen is dropped, address wraps
`timescale 1ns/1ps
module sag_top
    import sag_pkg::*;
#(
    parameter int SEG_WIDTH = SEG_W,
    parameter int OFFSET_WIDTH = OFS_W,
    parameter int ADDR_WIDTH = PA_W,
    parameter int SEL_WIDTH = REG_SEL_W
)
(
    input wire logic CLK,
    input wire logic RST_B,
    // access request, one address formed per valid cycle
    input wire logic REQ_VALID,
    input wire sag_req_t REQ,
    input wire logic [OFS_W-1:0] PREFETCH_POINTER,
    input wire logic [OFS_W-1:0] STACK_POINTER,
    input wire logic [OFS_W-1:0] SOURCE_INDEX_REGISTER,
    input wire logic [OFS_W-1:0] DESTINATION_INDEX_REGISTER,
    input wire logic [OFS_W-1:0] BASE_POINTER_REGISTER,
    input wire logic [OFS_W-1:0] BASE_GENERAL_REGISTER,
    input wire logic [OFS_W-1:0] ACCUMULATOR_WORD_REGISTER,
    input wire logic [OFS_W-1:0] COUNT_WORD_REGISTER,
    input wire logic [OFS_W-1:0] DATA_WORD_REGISTER,
    // segment base load from the execution unit
    input wire logic SEG_WR,
    input wire sag_seg_t SEG_WR_SEL,
    input wire logic [SEG_W-1:0] SEG_WR_DATA,
    // instruction sequencing
    input wire logic INSN_START,
    input wire logic [OFS_W-1:0] INSN_LEN,
    input wire logic BR_VALID,
    input wire sag_br_req_t BR,
    // memory read port for indirect targets
    input wire logic MEM_ACK,
    input wire logic [OFS_W-1:0] MEM_RDATA,
    output logic [PA_W-1:0] PHYS_ADDR,
    output logic PHYS_VALID,
    output logic MEM_RD,
    output logic [PA_W-1:0] MEM_ADDR,
    output logic BR_BUSY,
    output logic BR_DONE,
    output logic [OFS_W-1:0] PROGRAM_COUNTER,
    output sag_segs_t SEGS
);
    sag_segs_t segs;
    sag_segs_t next_segs;
    logic [OFS_W-1:0] pc;
    logic [OFS_W-1:0] next_pc;
    logic [PA_W-1:0] phys;
    logic [PA_W-1:0] next_phys;
    logic phys_valid;
    logic next_phys_valid;
    sag_state_t state;
    sag_state_t next_state;
    logic far_rd;
    logic next_far_rd;
    logic [PA_W-1:0] rd_addr;
    logic [PA_W-1:0] next_rd_addr;
    logic br_done;
    logic next_br_done;

    sag_seg_t sel_seg;
    logic [OFS_W-1:0] sel_ofs;
    logic [OFS_W-1:0] disp;
    logic [OFS_W-1:0] gpr;
    logic [OFS_W-1:0] ind_ofs;

    // ports and carrier structs are sized by the package, so only those
    // widths can be served; any other setting is refused here
    if (SEG_WIDTH != SEG_W) begin : g_seg_width_check
        $error("segment width differs from the carrier width");
    end
    if (OFFSET_WIDTH != OFS_W) begin : g_ofs_width_check
        $error("offset width differs from the carrier width");
    end
    if (ADDR_WIDTH != PA_W) begin : g_addr_width_check
        $error("address width differs from the carrier width");
    end
    if (ADDR_WIDTH != SEG_WIDTH + SEG_SHIFT) begin : g_shift_check
        $error("address width must be segment width plus the shift");
    end
    if (SEL_WIDTH != REG_SEL_W) begin : g_sel_width_check
        $error("register field must select one of eight registers");
    end

    // base shifted left four places plus unsigned offset, carry dropped
    function automatic logic [PA_W-1:0] form_addr(
        input logic [SEG_W-1:0] base,
        input logic [OFS_W-1:0] ofs
    );
        logic [PA_W-1:0] shifted;
        logic [PA_W-1:0] zext;
        shifted = {base, SEG_LOW_ZERO}; // [RL4]
        zext = {{(PA_W-OFS_W){1'b0}}, ofs}; // [RL2]
        return PA_W'(shifted + zext); // [RL1] [RL20]
    endfunction

    function automatic logic [SEG_W-1:0] seg_of(
        input sag_segs_t s,
        input sag_seg_t k
    );
        case (k)
            SAG_SEG_PROG: seg_of = s.prog;
            SAG_SEG_STACK: seg_of = s.stack;
            SAG_SEG_DATA0: seg_of = s.data0;
            SAG_SEG_DATA1: seg_of = s.data1;
            default: seg_of = s.data0;
        endcase
    endfunction

    // default segment and offset per access kind
    always_comb begin
        sel_seg = SAG_SEG_DATA0;
        sel_ofs = REQ.ea;
        case (REQ.kind)
            SAG_ACC_FETCH: begin
                sel_seg = SAG_SEG_PROG; // [RL6]
                sel_ofs = PREFETCH_POINTER;
            end
            SAG_ACC_STACK: begin
                sel_seg = SAG_SEG_STACK; // [RL7]
                sel_ofs = STACK_POINTER;
            end
            SAG_ACC_BP_DATA: begin
                sel_seg = SAG_SEG_STACK; // [RL8]
                sel_ofs = REQ.ea;
            end
            SAG_ACC_SRC_BLK: begin
                sel_seg = SAG_SEG_DATA0; // [RL11]
                sel_ofs = SOURCE_INDEX_REGISTER;
            end
            SAG_ACC_DST_BLK: begin
                sel_seg = SAG_SEG_DATA1; // [RL12]
                sel_ofs = DESTINATION_INDEX_REGISTER;
            end
            SAG_ACC_DATA: begin
                sel_seg = SAG_SEG_DATA0; // [RL10]
                sel_ofs = REQ.ea;
            end
            default: begin
                sel_seg = SAG_SEG_DATA0;
                sel_ofs = REQ.ea;
            end
        endcase
        // fetch and stack pushes use fixed segments; operands may be
        // redirected, and block destinations stay in data one
        if (REQ.override_en && REQ.kind != SAG_ACC_FETCH
                && REQ.kind != SAG_ACC_STACK
                && REQ.kind != SAG_ACC_DST_BLK) begin
            sel_seg = REQ.override_seg; // [RL9]
        end
    end

    // general register selected by the 3-bit field
    always_comb begin
        case (BR.reg_sel)
            REG_ACC: gpr = ACCUMULATOR_WORD_REGISTER;
            REG_CNT: gpr = COUNT_WORD_REGISTER;
            REG_DAT: gpr = DATA_WORD_REGISTER;
            REG_BASE: gpr = BASE_GENERAL_REGISTER;
            REG_SP: gpr = STACK_POINTER;
            REG_BP: gpr = BASE_POINTER_REGISTER;
            REG_SRC: gpr = SOURCE_INDEX_REGISTER;
            REG_DST: gpr = DESTINATION_INDEX_REGISTER;
            default: gpr = ACCUMULATOR_WORD_REGISTER;
        endcase
    end

    // displacement: narrow form sign extended, wide form used as is
    always_comb begin
        if (BR.disp_wide) begin
            disp = BR.imm_lo;
        end else begin
            disp = {{(OFS_W-DISP8_W){BR.imm_lo[DISP8_W-1]}},
                    BR.imm_lo[DISP8_W-1:0]}; // [RL15]
        end
        // pointer held in source index, destination index or base register
        case (BR.reg_sel)
            REG_SRC: ind_ofs = SOURCE_INDEX_REGISTER; // [RL18]
            REG_DST: ind_ofs = DESTINATION_INDEX_REGISTER;
            default: ind_ofs = BASE_GENERAL_REGISTER;
        endcase
        // index plus displacement wraps at sixteen bits like any offset
        if (BR.mode == SAG_BR_IDX) begin
            ind_ofs = OFS_W'(gpr + disp); // [RL19]
        end
    end

    // address output path
    // address and strobe are both registered so they leave together
    always_comb begin
        next_phys = phys;
        next_phys_valid = REQ_VALID;
        if (REQ_VALID) begin
            next_phys = form_addr(seg_of(segs, sel_seg), sel_ofs); // [RL3]
        end
    end

    // program counter, segment bases and indirect target sequencer
    // branch loads come after the segment write, so a far branch wins
    // over a program base write made in the same cycle
    always_comb begin
        next_segs = segs;
        next_pc = pc;
        next_state = state;
        next_far_rd = far_rd;
        next_rd_addr = rd_addr;
        next_br_done = 1'b0;
        // a request in the same cycle still sees the old base
        if (SEG_WR) begin
            case (SEG_WR_SEL) // [RL5]
                SAG_SEG_PROG: next_segs.prog = SEG_WR_DATA;
                SAG_SEG_STACK: next_segs.stack = SEG_WR_DATA;
                SAG_SEG_DATA0: next_segs.data0 = SEG_WR_DATA;
                SAG_SEG_DATA1: next_segs.data1 = SEG_WR_DATA;
                default: next_segs.data0 = SEG_WR_DATA;
            endcase
        end
        case (state)
            SAG_ST_IDLE: begin
                // a branch issued in the same cycle overwrites this advance;
                // while a read is pending the advance is not taken at all
                if (INSN_START) begin
                    next_pc = OFS_W'(pc + INSN_LEN); // [RL13]
                end
                if (BR_VALID) begin
                    case (BR.mode)
                        SAG_BR_DIRECT: begin
                            next_pc = BR.imm_lo; // [RL14]
                            if (BR.far_tgt) begin
                                next_segs.prog = BR.imm_hi;
                            end
                            next_br_done = 1'b1;
                        end
                        SAG_BR_REL: begin
                            // pc already points past the branch
                            next_pc = OFS_W'(pc + disp); // [RL16]
                            next_br_done = 1'b1;
                        end
                        SAG_BR_REG: begin
                            next_pc = gpr; // [RL17]
                            next_br_done = 1'b1;
                        end
                        SAG_BR_IND, SAG_BR_IDX: begin
                            // pointers always go through data zero
                            next_rd_addr = form_addr(segs.data0, ind_ofs);
                            next_far_rd = BR.far_tgt
                                && BR.mode == SAG_BR_IND; // [RL18]
                            next_state = SAG_ST_RD_LO;
                        end
                        default: begin
                            next_br_done = 1'b0;
                        end
                    endcase
                end
            end
            SAG_ST_RD_LO: begin
                if (MEM_ACK) begin
                    next_pc = MEM_RDATA; // [RL18] [RL19]
                    if (far_rd) begin
                        next_rd_addr = PA_W'(rd_addr + PTR_HI_STEP);
                        next_state = SAG_ST_RD_HI;
                    end else begin
                        next_state = SAG_ST_IDLE;
                        next_br_done = 1'b1;
                    end
                end
            end
            SAG_ST_RD_HI: begin
                if (MEM_ACK) begin
                    next_segs.prog = MEM_RDATA; // [RL18]
                    next_state = SAG_ST_IDLE;
                    next_br_done = 1'b1;
                end
            end
            default: begin
                next_state = SAG_ST_IDLE;
            end
        endcase
    end

    // address path registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            phys <= '0;
            phys_valid <= 1'b0;
        end else begin
            phys <= next_phys;
            phys_valid <= next_phys_valid;
        end
    end

    // sequencer registers; a reset in mid-branch drops the pending read
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            segs <= '{SEG_RESET, SEG_RESET, SEG_RESET, SEG_RESET};
            pc <= PC_RESET;
            state <= SAG_ST_IDLE;
            far_rd <= 1'b0;
            rd_addr <= '0;
            br_done <= 1'b0;
        end else begin
            segs <= next_segs;
            pc <= next_pc;
            state <= next_state;
            far_rd <= next_far_rd;
            rd_addr <= next_rd_addr;
            br_done <= next_br_done;
        end
    end

    assign PHYS_ADDR = phys;
    assign PHYS_VALID = phys_valid;
    // read request and busy are one signal: the sequencer only waits on memory
    assign MEM_RD = (state != SAG_ST_IDLE);
    assign MEM_ADDR = rd_addr;
    assign BR_BUSY = (state != SAG_ST_IDLE);
    assign BR_DONE = br_done;
    assign PROGRAM_COUNTER = pc;
    assign SEGS = segs;
endmodule

/* testbench/sag_checker_assertions.sv */
// port-level checker for the segmented address generator
`timescale 1ns/1ps
module sag_checker
    import sag_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic REQ_VALID,
    input wire sag_req_t REQ,
    input wire logic [OFS_W-1:0] PREFETCH_POINTER,
    input wire logic [OFS_W-1:0] STACK_POINTER,
    input wire logic [OFS_W-1:0] DESTINATION_INDEX_REGISTER,
    input wire logic [OFS_W-1:0] COUNT_WORD_REGISTER,
    input wire logic INSN_START,
    input wire logic [OFS_W-1:0] INSN_LEN,
    input wire logic BR_VALID,
    input wire sag_br_req_t BR,
    input wire logic [PA_W-1:0] PHYS_ADDR,
    input wire logic PHYS_VALID,
    input wire logic MEM_RD,
    input wire logic [PA_W-1:0] MEM_ADDR,
    input wire logic BR_BUSY,
    input wire logic BR_DONE,
    input wire logic [OFS_W-1:0] PROGRAM_COUNTER,
    input wire sag_segs_t SEGS
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    function automatic logic [15:0] seg_of(sag_segs_t s, sag_seg_t k);
        return k == SAG_SEG_PROG ? s.prog : k == SAG_SEG_STACK ? s.stack
            : k == SAG_SEG_DATA0 ? s.data0 : s.data1;
    endfunction
    property p_valid;
        REQ_VALID |=> PHYS_VALID;
    endproperty
    a_valid: assert property (p_valid)
        else $error("no address strobe after a request");
    property p_fetch;
        REQ_VALID && REQ.kind == SAG_ACC_FETCH |=> PHYS_ADDR ==
            {$past(SEGS.prog), 4'h0} + $past(PREFETCH_POINTER);
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("fetch address wrong");
    property p_stack;
        REQ_VALID && REQ.kind == SAG_ACC_STACK |=> PHYS_ADDR ==
            {$past(SEGS.stack), 4'h0} + $past(STACK_POINTER);
    endproperty
    a_stack: assert property (p_stack)
        else $error("stack address wrong");
    property p_bp;
        REQ_VALID && REQ.kind == SAG_ACC_BP_DATA && !REQ.override_en
        |=> PHYS_ADDR == {$past(SEGS.stack), 4'h0} + $past(REQ.ea);
    endproperty
    a_bp: assert property (p_bp)
        else $error("base pointer operand not in stack segment");
    property p_ovr;
        REQ_VALID && REQ.kind == SAG_ACC_DATA && REQ.override_en
        |=> PHYS_ADDR == {seg_of($past(SEGS), $past(REQ.override_seg)),
            4'h0} + $past(REQ.ea);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("override segment ignored");
    property p_reg;
        BR_VALID && !BR_BUSY && BR.mode == SAG_BR_REG && BR.reg_sel == REG_CNT
        |=> BR_DONE && PROGRAM_COUNTER == $past(COUNT_WORD_REGISTER);
    endproperty
    a_reg: assert property (p_reg)
        else $error("register branch target wrong");
    property p_rel;
        BR_VALID && !BR_BUSY && BR.mode == SAG_BR_REL && !BR.disp_wide
        |=> PROGRAM_COUNTER ==
            $past(PROGRAM_COUNTER) + 16'($signed($past(BR.imm_lo[7:0])));
    endproperty
    a_rel: assert property (p_rel)
        else $error("short relative target wrong");
    property p_insn;
        INSN_START && !BR_BUSY && !BR_VALID |=> PROGRAM_COUNTER ==
            $past(PROGRAM_COUNTER) + $past(INSN_LEN);
    endproperty
    a_insn: assert property (p_insn)
        else $error("counter not advanced");
    property p_ind;
        BR_VALID && !BR_BUSY && BR.mode == SAG_BR_IND && BR.reg_sel == REG_DST
        |=> MEM_RD && MEM_ADDR == {$past(SEGS.data0), 4'h0} +
            $past(DESTINATION_INDEX_REGISTER);
    endproperty
    a_ind: assert property (p_ind)
        else $error("indirect pointer address wrong");
endmodule
bind sag_top sag_checker i_chk (.*);

/* testbench/sag_mem_model.sv */
// external memory answering the branch target reads
`timescale 1ns/1ps
module sag_mem_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rd,
    input wire logic [19:0] addr,
    output logic ack = 1'b0,
    output logic [15:0] rdata = 16'h0000
);
    logic [1:0] wait_cnt;
    function automatic logic [15:0] word(logic [19:0] a);
        return a[15:0] ^ 16'hC35A;
    endfunction
    // random wait so both prompt and slow answers occur
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (ack || !rd || wait_cnt != 2'h0) begin
            ack <= 1'b0;
            // stale bus data toggles so it never matches by luck
            rdata <= ~rdata;
            wait_cnt <= ack ? 2'($urandom) : wait_cnt - 2'(wait_cnt != 0);
        end else begin
            ack <= 1'b1;
            rdata <= word(addr);
        end
    end
endmodule

/* testbench/sag_top_tb.sv */
// self-checking bench for the segmented address generator
`timescale 1ns/1ps
module sag_top_tb import sag_pkg::*;;
    logic CLK = 0, RST_B = 0, REQ_VALID = 0, SEG_WR = 0;
    logic INSN_START = 0, BR_VALID = 0, MEM_ACK, PHYS_VALID, MEM_RD;
    logic BR_BUSY, BR_DONE;
    logic [15:0] PREFETCH_POINTER = 0, SEG_WR_DATA = 0, INSN_LEN = 0;
    logic [15:0] MEM_RDATA, PROGRAM_COUNTER, pc = 0;
    logic [19:0] PHYS_ADDR, MEM_ADDR;
    logic [15:0] g[8] = '{default: 0};
    logic [15:0] sg[4] = '{default: 0};
    sag_req_t REQ = '0;
    sag_br_req_t BR = '0;
    sag_seg_t SEG_WR_SEL = SAG_SEG_PROG;
    sag_segs_t SEGS;
    logic [19:0] qa[$];
    logic [31:0] qb[$];
    int num_errors = 0, n_compared = 0, cycles = 0;
    always #5 CLK = ~CLK;
    sag_top i_dut (.*, .ACCUMULATOR_WORD_REGISTER(g[0]),
        .COUNT_WORD_REGISTER(g[1]), .DATA_WORD_REGISTER(g[2]),
        .BASE_GENERAL_REGISTER(g[3]), .STACK_POINTER(g[4]),
        .BASE_POINTER_REGISTER(g[5]), .SOURCE_INDEX_REGISTER(g[6]),
        .DESTINATION_INDEX_REGISTER(g[7]));
    sag_mem_model i_mem (.clk(CLK), .rst_b(RST_B), .rd(MEM_RD),
        .addr(MEM_ADDR), .ack(MEM_ACK), .rdata(MEM_RDATA));
    task automatic tick;
        @(posedge CLK);
        #1;
    endtask
    task automatic final_report;
        if (num_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic cmp_pa(logic [19:0] e, logic [19:0] s);
        n_compared++;
        if (e !== s) begin
            num_errors++;
            $display("wrong value PHYS_ADDR exp %h got %h", e, s);
        end
    endtask
    task automatic cmp_br(logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (e !== s) begin
            num_errors++;
            $display("wrong value prog_pc exp %h got %h", e, s);
        end
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            final_report;
        end
        if (PHYS_VALID === 1'b1)
            cmp_pa(qa.size() ? qa.pop_front() : 'x, PHYS_ADDR);
        if (BR_DONE === 1'b1)
            cmp_br(qb.size() ? qb.pop_front() : 'x,
                {SEGS.prog, PROGRAM_COUNTER});
    end
    task automatic wseg(int i, logic [15:0] v);
        SEG_WR = 1;
        SEG_WR_SEL = sag_seg_t'(i);
        SEG_WR_DATA = v;
        sg[i] = v;
        tick;
    endtask
    task automatic acc(sag_acc_t k, logic ov, sag_seg_t os, logic [15:0] ea);
        logic [15:0] o;
        int s;
        foreach (g[i]) g[i] = 16'($urandom);
        PREFETCH_POINTER = 16'($urandom);
        o = k == SAG_ACC_FETCH ? PREFETCH_POINTER : k == SAG_ACC_STACK ? g[4]
            : k == SAG_ACC_SRC_BLK ? g[6] : k == SAG_ACC_DST_BLK ? g[7] : ea;
        s = k == SAG_ACC_FETCH ? 0 : k == SAG_ACC_DST_BLK ? 3
            : k inside {SAG_ACC_STACK, SAG_ACC_BP_DATA} ? 1 : 2;
        if (ov && k inside {SAG_ACC_DATA, SAG_ACC_BP_DATA, SAG_ACC_SRC_BLK})
            s = os;
        qa.push_back({sg[s], 4'h0} + 20'(o));
        REQ = '{k, ov, os, ea};
        REQ_VALID = 1;
        tick;
    endtask
    task automatic br(sag_br_t m, logic far, logic w, logic [2:0] r);
        logic [15:0] lo, hi, d, p, t;
        logic [19:0] a;
        foreach (g[i]) g[i] = 16'($urandom);
        lo = 16'($urandom);
        hi = 16'($urandom);
        d = w ? lo : 16'($signed(lo[7:0]));
        p = m == SAG_BR_IDX ? g[r] + d : r == 6 ? g[6] : r == 7 ? g[7] : g[3];
        a = {sg[2], 4'h0} + 20'(p);
        t = m == SAG_BR_DIRECT ? lo : m == SAG_BR_REL ? pc + d
            : m == SAG_BR_REG ? g[r] : i_mem.word(a);
        if (far)
            sg[0] = m == SAG_BR_DIRECT ? hi : i_mem.word(a + 20'h2);
        pc = t;
        qb.push_back({sg[0], t});
        BR = '{m, far, w, lo, hi, r};
        BR_VALID = 1;
        tick;
        BR_VALID = 0;
        for (int i = 0; i < 40 && BR_DONE !== 1'b1; i++) tick;
        tick;
    endtask
    task automatic insn;
        INSN_LEN = 16'($urandom_range(1, 6));
        pc += INSN_LEN;
        INSN_START = 1;
        tick;
        INSN_START = 0;
    endtask
    initial begin
        void'($urandom(32'hF14DE15A));
        repeat (2) tick;
        RST_B = 1;
        for (int i = 0; i < 4; i++) wseg(i, 16'($urandom));
        SEG_WR = 0;
        for (int k = 0; k < 6; k++)
            for (int j = 0; j < 5; j++)
                acc(sag_acc_t'(k), j < 4, sag_seg_t'(j % 4),
                    16'($urandom));
        REQ_VALID = 0;
        wseg(2, 16'hFFFF);
        SEG_WR = 0;
        acc(SAG_ACC_DATA, 0, SAG_SEG_PROG, 16'h0000);
        acc(SAG_ACC_DATA, 0, SAG_SEG_PROG, 16'hFFFF);
        acc(SAG_ACC_DATA, 0, SAG_SEG_PROG, 16'h8000);
        REQ_VALID = 0;
        insn;
        br(SAG_BR_DIRECT, 0, 0, 0);
        br(SAG_BR_DIRECT, 1, 0, 0);
        for (int w = 0; w < 2; w++) begin
            insn;
            br(SAG_BR_REL, 0, w[0], 0);
        end
        for (int r = 0; r < 8; r++) br(SAG_BR_REG, 0, 0, 3'(r));
        for (int r = 5; r < 8; r++) br(SAG_BR_IND, r == 6, 0, 3'(r));
        br(SAG_BR_IDX, 0, 0, 3'h6);
        br(SAG_BR_IDX, 0, 1, 3'h7);
        repeat (3) tick;
        num_errors += qa.size() + qb.size();
        final_report;
    end
endmodule
